// *** include/stream_write_regs.svh ***
// constants for the streaming pio write command block
// assumes a 100 MHz core clock and a 16-bit register port
// Operation
// [R1] command byte 3Bh starts the streaming write with programmed data transfer
// [R2] sector count 1 to 65536; zero means 65536 sectors
// [R3] count high byte is the previous write, low byte the current write
// [R4] continue-on-error: finish all data, then stream fault set, error clear, logged
// [R5] continue-on-error and time limit expiry: stop, stream fault, log expiry flag
// [R6] always try to move all requested data within the time limit
// [R7] urgent option bit 7 asks fastest completion within the time limit
// [R8] flush option bit 5 commits stream data to media before completion
// [R9] resume option bit 4 starts at the stream's last reported error address
// [R10] option bits 2:0 select the stream and its stored settings
// [R11] time limit is previous option byte times identify words 99:98 microseconds
// [R12] zero byte uses the stream default; zero default means no limit
// [R13] limit runs from command byte write until completion interrupt
// [R14] on error the 48-bit first error address is returned, high bytes via select
// [R15] error bit 0 flags a completion time limit error
// [R16] on logged error: stream fault, first bad address, count of bad sectors
// [R17] with continue-on-error, error register bits go to the log instead
// [R18] status bit 4 flags a deferred write fault, location only in the log
// [R19] host on time-out should soft reset then retry
// [R20] host writes previous byte first, current byte second, then the command
// [R21] data request raised per sector; host writes one sector of words each time
// [R22] clean completion: busy clear, ready set, error clear, interrupt raised
`ifndef STREAM_WRITE_REGS_SVH
`define STREAM_WRITE_REGS_SVH
`define SW_OP_WRITE_PIO 8'h3b
`define SW_A_DATA 4'h0
`define SW_A_OPTIONS 4'h1
`define SW_A_COUNT 4'h2
`define SW_A_ADDR_LOW 4'h3
`define SW_A_ADDR_MID 4'h4
`define SW_A_ADDR_HIGH 4'h5
`define SW_A_DRIVE 4'h6
`define SW_A_OPCODE 4'h7
`define SW_A_DEVCTL 4'h8
`define SW_A_UNIT_LO 4'h9
`define SW_A_UNIT_HI 4'ha
`define SW_A_DEFAULT 4'hb
`define SW_A_LOG_FLAGS 4'hc
`define SW_A_LOG_LBA0 4'hd
`define SW_A_LOG_LBA1 4'he
`define SW_A_LOG_LBA2 4'hf
`define SW_F_URGENT 7
`define SW_F_CONTINUE 6
`define SW_F_FLUSH 5
`define SW_F_RESUME 4
`define SW_S_BUSY 7
`define SW_S_READY 6
`define SW_S_STREAM 5
`define SW_S_DEFER 4
`define SW_S_DRQ 3
`define SW_S_ERR 0
`define SW_E_CRC 7
`define SW_E_UNC 6
`define SW_E_ADDRESS_NOT_FOUND 4
`define SW_E_COMMAND_ABORTED 2
`define SW_E_TIME_LIMIT_EXPIRED 0
`define SW_DC_HOB 7
`define SW_DC_SRST 2
`define SW_WORDS_PER_SECTOR 9'd256
`define SW_CLK_NS 10
`define SW_US_NS 1000
`define SW_US_CYCLES ((`SW_US_NS + `SW_CLK_NS - 1) / `SW_CLK_NS)
`define SW_DRIVE_RESET 8'he0
`endif

// *** include/stream_write_pkg.sv ***
// types for the streaming pio write command block
// assumes stream_write_regs.svh for all numbers
package stream_write_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_SECTOR, ST_FLUSH} phase_t;
  typedef logic [47:0] lba_t;
  typedef logic [39:0] limit_t;
endpackage

// *** rtl/task_file_pair.sv ***
// one paired task-file byte register: current and previous byte
// assumes writes come from the core clock register port
module task_file_pair (
  // clock and reset
  input wire logic core_clk,
  input wire logic clear_n,
  // host side
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  // device side
  input wire logic load_en,
  input wire logic [15:0] load_val,
  output logic [7:0] cur,
  output logic [7:0] prev
);
  always_ff @(posedge core_clk) begin
    if (!clear_n) begin
      cur <= 8'h00;
      prev <= 8'h00;
    end else if (load_en) begin
      prev <= load_val[15:8];
      cur <= load_val[7:0];
    end else if (wr_en) begin
      prev <= cur; // R20 R3
      cur <= wr_byte;
    end
  end
endmodule

// *** rtl/time_limit_timer.sv ***
// completion time limit counter in microseconds
// assumes a limit of zero means no limit
`include "stream_write_regs.svh"
module time_limit_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic clear_n,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [39:0] limit_us,
  // result
  output logic expired
);
  localparam int US_CYC = `SW_US_CYCLES;
  logic [6:0] pre;
  logic [39:0] left;
  logic running;
  wire tick = running && (pre == 7'(US_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (!clear_n || stop) begin
      running <= 1'b0;
      pre <= 7'h00;
      left <= 40'h00_0000_0000;
      expired <= 1'b0;
    end else if (start) begin
      running <= (limit_us != 40'h00_0000_0000); // R12
      pre <= 7'h00;
      left <= limit_us;
      expired <= 1'b0;
    end else if (running) begin
      pre <= tick ? 7'h00 : pre + 7'h01;
      if (tick) begin
        left <= left - 40'h00_0000_0001;
        if (left == 40'h00_0000_0001) begin
          expired <= 1'b1;
          running <= 1'b0;
        end
      end
    end
  end
endmodule

// *** rtl/stream_write_ctrl.sv ***
// task-file decoder and execution control for the streaming pio write
// assumes media engine on core_clk; hard reset pin is asynchronous
`include "stream_write_regs.svh"
module stream_write_ctrl (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hard_reset_pin_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // host signals
  output logic intrq,
  output logic drq,
  // media engine, data path
  output logic media_word_valid,
  output logic [15:0] media_word,
  output logic media_start,
  output logic [47:0] media_lba,
  output logic [2:0] media_stream,
  output logic media_urgent,
  output logic media_flush_req,
  input wire logic media_flush_done,
  // media engine, faults
  input wire logic media_error,
  input wire logic [3:0] media_error_kind,
  input wire logic [47:0] media_error_lba,
  input wire logic deferred_fault,
  input wire logic [47:0] deferred_lba
);
  // hard reset pin synchroniser
  logic hard_meta;
  logic hard_sync;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hard_meta <= 1'b1;
      hard_sync <= 1'b1;
    end else begin
      hard_meta <= hard_reset_pin_n;
      hard_sync <= hard_meta;
    end
  end

  // register decode
  wire wr_data = reg_wr && reg_addr == `SW_A_DATA;
  wire wr_opt = reg_wr && reg_addr == `SW_A_OPTIONS;
  wire wr_cnt = reg_wr && reg_addr == `SW_A_COUNT;
  wire wr_lo = reg_wr && reg_addr == `SW_A_ADDR_LOW;
  wire wr_mid = reg_wr && reg_addr == `SW_A_ADDR_MID;
  wire wr_hi = reg_wr && reg_addr == `SW_A_ADDR_HIGH;
  wire wr_drv = reg_wr && reg_addr == `SW_A_DRIVE;
  wire wr_op = reg_wr && reg_addr == `SW_A_OPCODE;
  wire wr_dc = reg_wr && reg_addr == `SW_A_DEVCTL;
  wire wr_ulo = reg_wr && reg_addr == `SW_A_UNIT_LO;
  wire wr_uhi = reg_wr && reg_addr == `SW_A_UNIT_HI;
  wire wr_def = reg_wr && reg_addr == `SW_A_DEFAULT;
  wire rd_stat = reg_rd && reg_addr == `SW_A_OPCODE;

  // soft reset from device control, combined with hard and core reset
  logic srst_bit;
  wire srst_now = wr_dc && reg_wdata[`SW_DC_SRST];
  wire run_n = rst_n && hard_sync && !srst_now && !srst_bit;

  stream_write_pkg::phase_t phase;
  wire busy = phase != stream_write_pkg::ST_IDLE;
  wire tf_wr_ok = !busy;

  // paired task-file registers
  logic [7:0] opt_cur, opt_prev, cnt_cur, cnt_prev;
  logic [7:0] lo_cur, lo_prev, mid_cur, mid_prev, hi_cur, hi_prev;
  logic ret_load;
  logic [47:0] ret_lba;
  logic [15:0] ret_cnt;

  task_file_pair u_opt (
    .core_clk(core_clk), .clear_n(run_n),
    .wr_en(wr_opt && tf_wr_ok), .wr_byte(reg_wdata[7:0]),
    .load_en(1'b0), .load_val(16'h0000),
    .cur(opt_cur), .prev(opt_prev)
  );
  task_file_pair u_cnt (
    .core_clk(core_clk), .clear_n(run_n),
    .wr_en(wr_cnt && tf_wr_ok), .wr_byte(reg_wdata[7:0]),
    .load_en(ret_load), .load_val(ret_cnt), // R16
    .cur(cnt_cur), .prev(cnt_prev)
  );
  task_file_pair u_lo (
    .core_clk(core_clk), .clear_n(run_n),
    .wr_en(wr_lo && tf_wr_ok), .wr_byte(reg_wdata[7:0]),
    .load_en(ret_load), .load_val({ret_lba[31:24], ret_lba[7:0]}), // R14
    .cur(lo_cur), .prev(lo_prev)
  );
  task_file_pair u_mid (
    .core_clk(core_clk), .clear_n(run_n),
    .wr_en(wr_mid && tf_wr_ok), .wr_byte(reg_wdata[7:0]),
    .load_en(ret_load), .load_val({ret_lba[39:32], ret_lba[15:8]}),
    .cur(mid_cur), .prev(mid_prev)
  );
  task_file_pair u_hi (
    .core_clk(core_clk), .clear_n(run_n),
    .wr_en(wr_hi && tf_wr_ok), .wr_byte(reg_wdata[7:0]),
    .load_en(ret_load), .load_val({ret_lba[47:40], ret_lba[23:16]}),
    .cur(hi_cur), .prev(hi_prev)
  );

  // start of command
  wire op_hit = wr_op && !busy && reg_wdata[7:0] == `SW_OP_WRITE_PIO; // R1
  wire op_bad = wr_op && !busy && reg_wdata[7:0] != `SW_OP_WRITE_PIO;
  wire [2:0] sel = opt_cur[2:0]; // R10
  wire opt_urgent = opt_cur[`SW_F_URGENT];
  wire opt_cont = opt_cur[`SW_F_CONTINUE];
  wire opt_flush = opt_cur[`SW_F_FLUSH];
  wire opt_resume = opt_cur[`SW_F_RESUME];
  wire [15:0] cnt_word = {cnt_prev, cnt_cur}; // R3
  wire [16:0] cnt_total = (cnt_word == 16'h0000) ? 17'h1_0000 : {1'b0, cnt_word}; // R2
  wire [47:0] tf_lba = {hi_prev, mid_prev, lo_prev, hi_cur, mid_cur, lo_cur};

  // per-stream settings and the shared time unit
  logic [47:0] resume_lba [8];
  logic [7:0] default_limit [8];
  logic [31:0] time_unit;
  wire [47:0] start_lba = opt_resume ? resume_lba[sel] : tf_lba; // R9
  wire [7:0] limit_factor = (opt_prev != 8'h00) ? opt_prev : default_limit[sel]; // R12
  wire [39:0] limit_us = 40'(limit_factor) * 40'(time_unit); // R11

  // command state
  logic [16:0] remaining;
  logic [8:0] word_idx;
  logic cont_mode, flush_mode, err_flag, stream_fault, defer_flag;
  logic [7:0] err_reg, log_flags;
  logic [47:0] log_lba;
  logic first_seen;
  logic [15:0] bad_count;
  logic expired;
  logic done_pulse;

  time_limit_timer u_timer (
    .core_clk(core_clk), .clear_n(run_n),
    .start(op_hit), .stop(done_pulse), // R13
    .limit_us(limit_us), .expired(expired)
  );

  function automatic logic [7:0] kind_bits(input logic [3:0] k);
    kind_bits = 8'h00;
    kind_bits[`SW_E_CRC] = k[3];
    kind_bits[`SW_E_UNC] = k[2];
    kind_bits[`SW_E_ADDRESS_NOT_FOUND] = k[1];
    kind_bits[`SW_E_COMMAND_ABORTED] = k[0];
  endfunction

  function automatic logic [7:0] pick(input logic high_order_byte_select, input logic [7:0] c,
                                      input logic [7:0] p);
    pick = high_order_byte_select ? p : c;
  endfunction

  wire err_hit = busy && media_error;
  wire last_word = wr_data && drq && word_idx == `SW_WORDS_PER_SECTOR - 9'd1;
  wire last_sector = remaining == 17'h0_0001;
  wire data_done = last_word && last_sector;
  wire stop_err = err_hit && !cont_mode;
  wire stop_time = busy && expired; // R5
  wire flush_end = phase == stream_write_pkg::ST_FLUSH && media_flush_done;
  wire to_flush = data_done && flush_mode;
  wire finish_ok = (data_done && !flush_mode) || flush_end;
  wire [15:0] next_bad = (bad_count == 16'hffff) ? bad_count : bad_count + 16'h0001;
  logic high_order_byte_select;

  always_ff @(posedge core_clk) begin
    if (!rst_n || !hard_sync) begin
      srst_bit <= 1'b0;
    end else if (wr_dc) begin
      srst_bit <= reg_wdata[`SW_DC_SRST];
    end
  end

  // host-set configuration
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      time_unit <= 32'h0000_0000;
      high_order_byte_select <= 1'b0;
      for (int i = 0; i < 8; i++) default_limit[i] <= 8'h00;
    end else begin
      if (wr_ulo) time_unit[15:0] <= reg_wdata;
      if (wr_uhi) time_unit[31:16] <= reg_wdata;
      if (wr_dc) high_order_byte_select <= reg_wdata[`SW_DC_HOB]; // R14
      if (wr_def) default_limit[reg_wdata[10:8]] <= reg_wdata[7:0]; // R12
    end
  end

  // drive select byte
  logic [7:0] drive_sel;
  always_ff @(posedge core_clk) begin
    if (!run_n) drive_sel <= `SW_DRIVE_RESET;
    else if (wr_drv && tf_wr_ok) drive_sel <= reg_wdata[7:0];
  end

  // main sequence
  always_ff @(posedge core_clk) begin
    if (!run_n) begin
      phase <= stream_write_pkg::ST_IDLE;
      remaining <= 17'h0_0000;
      word_idx <= 9'h000;
      cont_mode <= 1'b0;
      flush_mode <= 1'b0;
      drq <= 1'b0;
      done_pulse <= 1'b0;
      media_start <= 1'b0;
      media_lba <= 48'h0000_0000_0000;
      media_stream <= 3'h0;
      media_urgent <= 1'b0;
      media_flush_req <= 1'b0;
    end else begin
      done_pulse <= 1'b0;
      media_start <= 1'b0;
      case (phase)
        stream_write_pkg::ST_IDLE: begin
          if (op_hit) begin
            phase <= stream_write_pkg::ST_DATA;
            remaining <= cnt_total; // R2
            word_idx <= 9'h000;
            cont_mode <= opt_cont;
            flush_mode <= opt_flush;
            drq <= 1'b1; // R21
            media_start <= 1'b1;
            media_lba <= start_lba; // R9
            media_stream <= sel; // R10
            media_urgent <= opt_urgent; // R7
          end else if (op_bad) begin
            done_pulse <= 1'b1;
          end
        end
        stream_write_pkg::ST_DATA: begin
          if (stop_err || stop_time) begin
            phase <= stream_write_pkg::ST_IDLE;
            drq <= 1'b0;
            done_pulse <= 1'b1;
          end else if (last_word) begin
            drq <= 1'b0;
            word_idx <= 9'h000;
            remaining <= remaining - 17'h0_0001;
            if (to_flush) begin
              phase <= stream_write_pkg::ST_FLUSH;
              media_flush_req <= 1'b1; // R8
            end else if (last_sector) begin
              phase <= stream_write_pkg::ST_IDLE;
              done_pulse <= 1'b1;
            end else begin
              phase <= stream_write_pkg::ST_SECTOR; // R6
            end
          end else if (wr_data && drq) begin
            word_idx <= word_idx + 9'd1;
          end
        end
        stream_write_pkg::ST_SECTOR: begin
          if (stop_err || stop_time) begin
            phase <= stream_write_pkg::ST_IDLE;
            done_pulse <= 1'b1;
          end else begin
            phase <= stream_write_pkg::ST_DATA;
            drq <= 1'b1; // R21
          end
        end
        stream_write_pkg::ST_FLUSH: begin
          if (stop_err || stop_time || flush_end) begin
            phase <= stream_write_pkg::ST_IDLE;
            media_flush_req <= 1'b0;
            done_pulse <= 1'b1; // R8
          end
        end
        default: phase <= stream_write_pkg::ST_IDLE;
      endcase
    end
  end

  // data words to the media engine
  always_ff @(posedge core_clk) begin
    if (!run_n) begin
      media_word_valid <= 1'b0;
      media_word <= 16'h0000;
    end else begin
      media_word_valid <= wr_data && drq;
      if (wr_data && drq) media_word <= reg_wdata;
    end
  end

  // error tracking and ending status
  always_ff @(posedge core_clk) begin
    if (!run_n) begin
      err_flag <= 1'b0;
      stream_fault <= 1'b0;
      err_reg <= 8'h00;
      log_flags <= 8'h00;
      first_seen <= 1'b0;
      bad_count <= 16'h0000;
      ret_lba <= 48'h0000_0000_0000;
      ret_load <= 1'b0;
      ret_cnt <= 16'h0000;
      for (int i = 0; i < 8; i++) resume_lba[i] <= 48'h0000_0000_0000;
    end else begin
      ret_load <= 1'b0;
      if (op_hit) begin
        err_flag <= 1'b0; // R22
        stream_fault <= 1'b0;
        err_reg <= 8'h00;
        log_flags <= 8'h00;
        first_seen <= 1'b0;
        bad_count <= 16'h0000;
      end else if (op_bad) begin
        err_flag <= 1'b1;
        err_reg <= 8'h00 | (8'h01 << `SW_E_COMMAND_ABORTED);
      end
      if (err_hit) begin
        bad_count <= next_bad;
        if (!first_seen) begin
          first_seen <= 1'b1;
          ret_lba <= media_error_lba; // R14
          resume_lba[media_stream] <= media_error_lba; // R9
        end
        if (cont_mode) begin
          stream_fault <= 1'b1; // R4 R16
          log_flags <= log_flags | kind_bits(media_error_kind); // R17
        end else begin
          err_flag <= 1'b1;
          err_reg <= kind_bits(media_error_kind);
        end
      end
      if (stop_time) begin
        if (cont_mode) begin
          stream_fault <= 1'b1; // R5
          log_flags[`SW_E_TIME_LIMIT_EXPIRED] <= 1'b1; // R17
        end else begin
          err_flag <= 1'b1;
          err_reg[`SW_E_TIME_LIMIT_EXPIRED] <= 1'b1; // R15
        end
      end
      if (done_pulse && (stream_fault || err_flag) && first_seen) begin
        ret_load <= 1'b1; // R16
        ret_cnt <= bad_count;
      end
    end
  end

  // deferred fault flag and log address
  always_ff @(posedge core_clk) begin
    if (!run_n) begin
      defer_flag <= 1'b0;
      log_lba <= 48'h0000_0000_0000;
    end else if (deferred_fault) begin
      defer_flag <= 1'b1; // R18
      log_lba <= deferred_lba; // R18
    end else if (op_hit) begin
      defer_flag <= 1'b0;
    end
  end

  // completion interrupt, cleared by status read; a new event wins
  always_ff @(posedge core_clk) begin
    if (!run_n) intrq <= 1'b0;
    else if (done_pulse) intrq <= 1'b1; // R22
    else if (rd_stat || op_hit) intrq <= 1'b0;
  end

  // status and read mux
  wire [7:0] status = {busy, 1'b1, stream_fault, defer_flag, drq, 2'b00, err_flag};
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `SW_A_OPTIONS: rd_mux = {8'h00, err_reg};
      `SW_A_COUNT: rd_mux = {8'h00, pick(high_order_byte_select, cnt_cur, cnt_prev)};
      `SW_A_ADDR_LOW: rd_mux = {8'h00, pick(high_order_byte_select, lo_cur, lo_prev)};
      `SW_A_ADDR_MID: rd_mux = {8'h00, pick(high_order_byte_select, mid_cur, mid_prev)};
      `SW_A_ADDR_HIGH: rd_mux = {8'h00, pick(high_order_byte_select, hi_cur, hi_prev)};
      `SW_A_DRIVE: rd_mux = {8'h00, drive_sel};
      `SW_A_OPCODE: rd_mux = {8'h00, status};
      `SW_A_UNIT_LO: rd_mux = time_unit[15:0];
      `SW_A_UNIT_HI: rd_mux = time_unit[31:16];
      `SW_A_LOG_FLAGS: rd_mux = {8'h00, log_flags};
      `SW_A_LOG_LBA0: rd_mux = log_lba[15:0];
      `SW_A_LOG_LBA1: rd_mux = log_lba[31:16];
      `SW_A_LOG_LBA2: rd_mux = log_lba[47:32];
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) reg_rdata <= 16'h0000;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 16'h0000;
  end
endmodule

// *** tb/stream_write_ctrl_props.sv ***
// checker for the streaming pio write control block ports
// assumes one core clock domain, sync low reset and hard reset pin
module stream_write_ctrl_props (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hard_reset_pin_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // host and media
  input wire logic intrq,
  input wire logic drq,
  input wire logic media_word_valid,
  input wire logic [15:0] media_word,
  input wire logic media_start,
  input wire logic [47:0] media_lba,
  input wire logic [2:0] media_stream,
  input wire logic media_urgent,
  input wire logic media_flush_req,
  input wire logic media_flush_done
);
  logic active;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n || !hard_reset_pin_n);
  // command in flight from start until completion
  always_ff @(posedge core_clk) begin
    if (!rst_n || !hard_reset_pin_n) active <= 1'b0;
    else if (media_start) active <= 1'b1;
    else if (intrq) active <= 1'b0;
  end
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> !intrq && !drq && !media_start)
    else $error("outputs busy after reset");
  AST_START: assert property (reg_wr && reg_addr == 4'h7 && reg_wdata[7:0] == 8'h3b
    && !active && !media_start |=> media_start && drq) else $error("opcode not started");
  AST_WORD: assert property (drq && reg_wr && reg_addr == 4'h0
    |=> media_word_valid && media_word == $past(reg_wdata)) else $error("data word lost");
  AST_WORD_SRC: assert property (media_word_valid |-> $past(drq) && $past(reg_wr)
    && $past(reg_addr) == 4'h0) else $error("word without request");
  AST_STABLE: assert property (drq && $past(drq) |-> $stable(media_lba)
    && $stable(media_stream) && $stable(media_urgent)) else $error("command fields moved");
  AST_FLUSH: assert property (media_flush_req && !media_flush_done |=> !$rose(intrq))
    else $error("completion before flush");
  AST_INTRQ_CLR: assert property (reg_rd && reg_addr == 4'h7 && !active
    && !media_start && !$past(reg_wr) |=> !intrq) else $error("status read kept interrupt");
  AST_IDLE_DRQ: assert property (!active && !media_start |-> !drq)
    else $error("data request while idle");
  cover property (media_start && media_urgent);
  cover property (media_flush_req ##1 media_flush_done);
  cover property ($rose(intrq));
endmodule

bind stream_write_ctrl stream_write_ctrl_props chk (.core_clk, .rst_n, .hard_reset_pin_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .intrq, .drq, .media_word_valid,
  .media_word, .media_start, .media_lba, .media_stream, .media_urgent, .media_flush_req,
  .media_flush_done);

// *** tb/media_engine_model.sv ***
// media engine model on the far side of the streaming write control
// assumes words counted from each start; zero err_at means no fault
module media_engine_model #(
  parameter logic [47:0] err_lba = 48'h0000_0000_0000,
  parameter logic [47:0] dfr_lba = 48'h0000_0000_0000
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // from the control block
  input wire logic media_start,
  input wire logic media_word_valid,
  input wire logic media_flush_req,
  // scenario controls
  input wire logic [15:0] err_at,
  input wire logic [15:0] flush_lag,
  input wire logic dfr_go,
  // to the control block
  output logic media_flush_done,
  output logic media_error,
  output logic [3:0] media_error_kind,
  output logic [47:0] media_error_lba,
  output logic deferred_fault,
  output logic [47:0] deferred_lba
);
  logic [15:0] words;
  logic [15:0] waits;
  logic hit;
  assign hit = media_word_valid && (words + 16'h0001) == err_at;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      words <= 16'h0000;
      waits <= 16'h0000;
      media_flush_done <= 1'b0;
      media_error <= 1'b0;
      deferred_fault <= 1'b0;
    end else begin
      words <= media_start ? 16'h0000 : words + {15'h0000, media_word_valid};
      waits <= media_flush_req ? waits + 16'h0001 : 16'h0000;
      media_flush_done <= media_flush_req && waits == flush_lag;
      media_error <= hit;
      deferred_fault <= dfr_go;
    end
  end
  // fault details are junk outside their pulse
  always_ff @(posedge core_clk) begin
    media_error_kind <= hit ? 4'h8 : ~media_error_kind;
    media_error_lba <= hit ? err_lba : ~media_error_lba;
    deferred_lba <= dfr_go ? dfr_lba : ~deferred_lba;
  end
endmodule

// *** tb/stream_write_ctrl_tb.sv ***
// self-checking bench for the streaming pio write control block
// assumes the media engine model on the far side and one clock
module stream_write_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] err_lba = 48'h1357_9bdf_2468;
  localparam logic [47:0] dfr_lba = 48'h0000_0000_5a5a;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hard_reset_pin_n = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_q = 1'b0;
  logic dfr_go = 1'b0;
  logic [15:0] err_at = 16'h0000;
  logic [15:0] flush_lag = 16'h0014;
  logic [15:0] reg_rdata, media_word;
  logic intrq, drq, media_word_valid, media_start, media_urgent, media_flush_req;
  logic media_flush_done, media_error, deferred_fault;
  logic [3:0] media_error_kind;
  logic [47:0] media_lba, media_error_lba, deferred_lba;
  logic [2:0] media_stream;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  int seed = 32'h2ad262e2;
  logic [63:0] rq[$], wq[$], cq[$];
  always #5 core_clk = ~core_clk;
  stream_write_ctrl dut (.core_clk, .rst_n, .hard_reset_pin_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .intrq, .drq, .media_word_valid, .media_word,
    .media_start, .media_lba, .media_stream, .media_urgent, .media_flush_req,
    .media_flush_done, .media_error, .media_error_kind, .media_error_lba,
    .deferred_fault, .deferred_lba);
  media_engine_model #(.err_lba(err_lba), .dfr_lba(dfr_lba)) media (.core_clk, .rst_n,
    .media_start, .media_word_valid, .media_flush_req, .err_at, .flush_lag, .dfr_go,
    .media_flush_done, .media_error, .media_error_kind, .media_error_lba,
    .deferred_fault, .deferred_lba);
  task automatic end_sim();
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rq.push_back({48'h0, e});
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic idle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_for(input bit w);
    while ((w ? intrq : drq) !== 1'b1) @(posedge core_clk);
  endtask
  // options and count go previous byte first, then the opcode
  task automatic cmd(input logic [15:0] opt, input logic [15:0] cnt, input logic [47:0] a);
    wr(4'h1, {8'h00, opt[15:8]});
    wr(4'h1, {8'h00, opt[7:0]});
    wr(4'h2, {8'h00, cnt[15:8]});
    wr(4'h2, {8'h00, cnt[7:0]});
    for (int i = 0; i < 3; i++) begin
      wr(4'(3 + i), {8'h00, a[24 + 8 * i +: 8]});
      wr(4'(3 + i), {8'h00, a[8 * i +: 8]});
    end
    wr(4'h7, 16'h003b);
    idle();
  endtask
  task automatic sectors(input int n);
    logic [15:0] d;
    for (int s = 0; s < n; s++) begin
      wait_for(1'b0);
      for (int w = 0; w < 256; w++) begin
        d = 16'($random(seed));
        wq.push_back({48'h0, d});
        wr(4'h0, d);
      end
      idle();
    end
  endtask
  always @(posedge core_clk) begin
    rd_q <= reg_rd;
    cyc <= cyc + 1;
    if (rd_q) chk("reg_rdata", rq.pop_front(), {48'h0, reg_rdata});
    if (media_word_valid) chk("media_word", wq.pop_front(), {48'h0, media_word});
    if (media_flush_done) chk("flush", 1, media_flush_req);
    if (media_start) chk("start", cq.pop_front(), {12'h0, media_urgent, media_stream, media_lba});
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(4'h7, 16'h0040);
    dfr_go <= 1'b1;
    idle();
    dfr_go <= 1'b0;
    repeat (3) idle();
    rd(4'h7, 16'h0050);
    rd(4'hd, dfr_lba[15:0]);
    wr(4'h9, 16'h0001);
    wr(4'ha, 16'h0000);
    cq.push_back({12'h0, 1'b1, 3'd3, 48'h0000_8000_0010});
    cmd(16'h0083, 16'h0002, 48'h0000_8000_0010);
    sectors(2);
    wait_for(1'b1);
    rd(4'h7, 16'h0040);
    err_at <= 16'd300;
    cq.push_back({12'h0, 1'b0, 3'd1, 48'h0000_0000_0100});
    cmd(16'h0041, 16'h0002, 48'h0000_0000_0100);
    sectors(2);
    wait_for(1'b1);
    rd(4'h7, 16'h0060);
    rd(4'hc, 16'h0080);
    rd(4'h3, {8'h00, err_lba[7:0]});
    rd(4'h2, 16'h0001);
    wr(4'h8, 16'h0080);
    rd(4'h3, {8'h00, err_lba[31:24]});
    wr(4'h8, 16'h0000);
    err_at <= 16'h0000;
    cq.push_back({12'h0, 1'b0, 3'd1, err_lba});
    cmd(16'h0011, 16'h0001, 48'h0000_0000_0000);
    sectors(1);
    wait_for(1'b1);
    cq.push_back({12'h0, 1'b0, 3'd0, 48'h0000_0000_0020});
    cmd(16'h0020, 16'h0001, 48'h0000_0000_0020);
    sectors(1);
    wait_for(1'b1);
    rd(4'h7, 16'h0040);
    hard_reset_pin_n <= 1'b0;
    repeat (4) idle();
    hard_reset_pin_n <= 1'b1;
    repeat (4) idle();
    cq.push_back({12'h0, 1'b0, 3'd2, 48'h0000_0000_0030});
    cmd(16'h0142, 16'h0001, 48'h0000_0000_0030);
    t0 = cyc;
    wait_for(1'b1);
    chk("limit", 64'h1, {63'h0, (cyc - t0) >= 90 && (cyc - t0) <= 110});
    rd(4'h7, 16'h0060);
    rd(4'hc, 16'h0001);
    wr(4'h8, 16'h0004);
    wr(4'h8, 16'h0000);
    rd(4'h7, 16'h0040);
    wr(4'h7, 16'h0030);
    rd(4'h7, 16'h0041);
    rd(4'h1, 16'h0004);
    idle();
    idle();
    chk("queues", 0, rq.size() + wq.size() + cq.size());
    end_sim();
  end
endmodule
